// ### core/rsc_regs.sv
// register bank for the low-power sensor domain: converters, touch, dac tone
// assumes apb master on pclk; far-side inputs synchronous to pclk
// Notes on behaviour
// - invert bit complements stored conversion result
// - owner bit hands converter to digital controller
// - resolution code 00..11 means 9..12 bits
// - coprocessor start from software or sleep timer
// - halt bit stops that converter's conversion
// - two attenuation bits per converter pad
// - pad bitmap from register only when overridden
// - conversion start from software only when forced
// - read-only done flag and result per converter
// - wake on set one, or both sets
// - sense bit picks above or below threshold
// - wait then measure, both in 8 MHz ticks
// - ten pads with threshold and read counter
// - touched bitmap, done flag, clear bit
// - touch start from software or timer
// - sequencer or register bits drive touch controls
// - set touched if any member pad touched
// - dac memory feed and clock invert/force
// - tone enable and 16-bit frequency step
// - per-channel source: tone or register code
// - invert field reshapes generator output bits
// - scale by shifting, then add dc offset
// - phase accumulator adds step every clock
// - offset addition saturates at the upper 8-bit limit, 8'hff
//
// Added by the designer: the APB register port.
`include "rsc_consts.svh"
module rsc_regs
  import rsc_pkg::*;
#(
  parameter int PADS = 10
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire rsc_conv_in_s [1:0]    conv_in,
  input  wire logic [1:0]            cop_conv_start,
  input  wire logic [1:0][9:0]       cop_padmap,
  input  wire logic                  cop_timer_tick,
  output logic      [1:0]            conv_digital_owner,
  output logic      [1:0][1:0]       conv_resolution,
  output logic      [1:0]            conv_halt,
  output logic      [1:0]            conv_start,
  output logic      [1:0][9:0]       conv_padmap,
  output logic      [1:0][31:0]      conv_attenuation,
  output logic                       coproc_start,
  output logic      [31:0]           coproc_sleep_cycles,
  input  wire logic                  tick_8m,
  input  wire logic                  touch_timer_tick,
  input  wire logic [PADS-1:0][15:0] touch_count_in,
  output logic                       touch_start,
  output logic                       touch_powerup,
  output logic      [PADS-1:0]       touch_scan_pads,
  output logic                       touch_wake_irq,
  input  wire logic                  dac_dma_clk,
  input  wire logic [1:0][7:0]       dac_dma_data,
  input  wire logic                  dac_clk_in,
  output logic                       dac_clk,
  output logic      [1:0][7:0]       dac_code
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  localparam int NREG = 19;
  localparam logic [4:0] NO_REG = 5'h1f;

  function automatic logic [4:0] reg_index(input logic [11:0] a);
    logic [4:0] idx;
    idx = NO_REG;
    if (a[11:8] == 4'h0) begin
      case (a[7:0])
        `RSC_OFS_CONV1_READ_CONTROL:    idx = 5'd0;
        `RSC_OFS_COPROC_SLEEP_CYCLES:   idx = 5'd1;
        `RSC_OFS_START_FORCE_CONTROL:   idx = 5'd2;
        `RSC_OFS_CONV1_PAD_ATTENUATION: idx = 5'd3;
        `RSC_OFS_CONV2_PAD_ATTENUATION: idx = 5'd4;
        `RSC_OFS_CONV1_MEASURE_START:   idx = 5'd5;
        `RSC_OFS_TOUCH_CONTROL_ONE:     idx = 5'd6;
        8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c: begin
          idx = 5'(5'd7 + 5'((a[7:0] - `RSC_OFS_TOUCH_THRESHOLD_BASE) >> 2));
        end
        8'h70, 8'h74, 8'h78, 8'h7c, 8'h80: begin
          idx = 5'(5'd19 + 5'((a[7:0] - `RSC_OFS_TOUCH_COUNTER_BASE) >> 2));
        end
        `RSC_OFS_TOUCH_CONTROL_TWO:     idx = 5'd12;
        `RSC_OFS_TOUCH_PAD_SETS:        idx = 5'd13;
        `RSC_OFS_CONV2_READ_CONTROL:    idx = 5'd14;
        `RSC_OFS_CONV2_MEASURE_START:   idx = 5'd15;
        `RSC_OFS_DAC_TONE_CONTROL:      idx = 5'd16;
        `RSC_OFS_DAC_OUTPUT_CONTROL:    idx = 5'd17;
        `RSC_OFS_DAC_MANUAL_CODES:      idx = 5'd18;
        default:                        idx = NO_REG;
      endcase
    end
    return idx;
  endfunction

  function automatic logic [31:0] wr_mask(input int i);
    logic [31:0] m;
    m = `RSC_MSK_ALL;
    case (i)
      0, 14:   m = `RSC_MSK_READ_CONTROL;
      2:       m = `RSC_MSK_START_FORCE;
      5, 15:   m = `RSC_MSK_MEASURE_START;
      6:       m = `RSC_MSK_TOUCH_CONTROL_ONE;
      12:      m = `RSC_MSK_TOUCH_CONTROL_TWO;
      13:      m = `RSC_MSK_TOUCH_PAD_SETS;
      16:      m = `RSC_MSK_DAC_TONE;
      17:      m = `RSC_MSK_DAC_OUTPUT;
      18:      m = `RSC_MSK_DAC_CODES;
      default: m = `RSC_MSK_ALL;
    endcase
    return m;
  endfunction

  logic [31:0] ctl [NREG];
  logic [4:0]  idx;
  logic        setup_ph;
  logic        wr_go;
  assign idx      = reg_index(paddr);
  assign setup_ph = psel & ~penable;
  assign wr_go    = psel & penable & pready & pwrite & (idx != NO_REG);

  // ------------------------------------------------------------
  // writable storage; read-only bits are masked off
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_ctl
      localparam logic [31:0] RST = (g == 3 || g == 4) ? `RSC_RST_ATTENUATION : 32'h0;
      localparam logic [31:0] MSK = wr_mask(g);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl[g] <= RST;
        end else if (wr_go && idx == 5'(g)) begin
          ctl[g] <= (ctl[g] & ~MSK) | (pwdata & MSK);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // field views
  // ------------------------------------------------------------
  logic [1:0]  invert_bit;
  logic [1:0]  trig_sel;
  logic [1:0]  trig_sw;
  logic [1:0]  pad_ovr;
  logic [1:0][9:0] pad_reg;
  assign invert_bit = {ctl[14][3], ctl[0][3]};
  assign trig_sel   = {ctl[15][0], ctl[5][0]};
  assign trig_sw    = {ctl[15][1], ctl[5][1]};
  assign pad_ovr    = {ctl[15][2], ctl[5][2]};
  assign pad_reg    = {ctl[15][17:8], ctl[5][17:8]};

  logic        t_sense;
  logic        t_single;
  logic [7:0]  t_wait;
  logic [15:0] t_meas;
  logic        t_clr;
  logic        t_fsel;
  logic        t_fsw;
  logic        t_seq_own;
  logic [PADS-1:0] set_one;
  logic [PADS-1:0] set_two;
  logic [PADS-1:0] scan_set;
  assign t_wait    = ctl[6][7:0];
  assign t_meas    = ctl[6][23:8];
  assign t_sense   = ctl[6][24];
  assign t_single  = ctl[6][25];
  assign t_clr     = wr_go && idx == 5'd12 && pwdata[0];
  assign t_fsel    = ctl[12][1];
  assign t_fsw     = ctl[12][2];
  assign t_seq_own = ctl[12][3];
  assign set_one   = ctl[13][PADS-1:0];
  assign set_two   = ctl[13][PADS+9:10];
  assign scan_set  = ctl[13][PADS+19:20];

  // ------------------------------------------------------------
  // converter status capture
  // ------------------------------------------------------------
  logic [1:0]       conv_done;
  logic [1:0][11:0] conv_result;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done   <= '0;
      conv_result <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        conv_done[c] <= conv_in[c].done;
        if (conv_in[c].done) begin
          conv_result[c] <= invert_bit[c] ? ~conv_in[c].result : conv_in[c].result;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // converter and coprocessor controls
  // ------------------------------------------------------------
  logic sw_go_write;
  assign sw_go_write = wr_go && idx == 5'd2 && pwdata[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_digital_owner  <= '0;
      conv_resolution     <= '0;
      conv_halt           <= '0;
      conv_start          <= '0;
      conv_padmap         <= '0;
      conv_attenuation    <= '0;
      coproc_start        <= 1'b0;
      coproc_sleep_cycles <= '0;
    end else begin
      conv_digital_owner  <= {ctl[14][2], ctl[0][2]};
      conv_resolution     <= {ctl[14][1:0], ctl[0][1:0]};
      conv_halt           <= ctl[2][1:0];
      conv_attenuation    <= {ctl[4], ctl[3]};
      coproc_sleep_cycles <= ctl[1];
      for (int c = 0; c < 2; c++) begin
        conv_start[c]  <= trig_sel[c] ? trig_sw[c] : cop_conv_start[c];
        conv_padmap[c] <= pad_ovr[c] ? pad_reg[c] : cop_padmap[c];
      end
      // a software write only counts while software owns the start
      coproc_start <= ctl[2][3] ? sw_go_write : cop_timer_tick;
    end
  end

  // ------------------------------------------------------------
  // touch sequencer
  // ------------------------------------------------------------
  rsc_touch_e      ts;
  rsc_touch_e      next_ts;
  logic [15:0]     tcnt;
  logic            t_done;
  logic [PADS-1:0] touched_map;
  logic [PADS-1:0] pad_hit;
  logic            t_trig;
  logic            cnt_end;
  logic            seq_start;
  logic            seq_pwr;

  for (genvar p = 0; p < PADS; p++) begin : g_pad
    logic [15:0] thr;
    assign thr = p[0] ? ctl[7 + p/2][31:16] : ctl[7 + p/2][15:0];
    assign pad_hit[p] = scan_set[p] &&
      (t_sense ? (touch_count_in[p] > thr) : (touch_count_in[p] < thr));
  end

  assign t_trig  = t_fsel ? t_fsw : touch_timer_tick;
  assign cnt_end = tick_8m && (tcnt == 16'h0);

  always_comb begin
    next_ts = ts;
    case (ts)
      TS_IDLE: if (t_trig) next_ts = TS_WAIT;
      TS_WAIT: if (cnt_end) next_ts = TS_MEAS;
      TS_MEAS: if (cnt_end) next_ts = TS_DONE;
      TS_DONE: next_ts = TS_IDLE;
      default: next_ts = TS_IDLE;
    endcase
  end

  assign seq_start = ts != TS_IDLE && ts != TS_DONE;
  assign seq_pwr   = ts == TS_MEAS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts          <= TS_IDLE;
      tcnt        <= '0;
      t_done      <= 1'b0;
      touched_map <= '0;
    end else begin
      ts <= next_ts;
      if (ts == TS_IDLE || (ts == TS_WAIT && cnt_end)) begin
        tcnt <= (ts == TS_IDLE) ? {8'h0, t_wait} : t_meas;
      end else if (tick_8m && tcnt != 16'h0) begin
        tcnt <= tcnt - 16'h1;
      end
      if (ts == TS_DONE) begin
        t_done <= 1'b1;
      end else if (ts == TS_IDLE && t_trig) begin
        t_done <= 1'b0;
      end
      // a new result wins over a clear in the same cycle
      touched_map <= (t_clr ? '0 : touched_map) | (ts == TS_DONE ? pad_hit : '0);
    end
  end

  logic set_one_hit;
  logic set_two_hit;
  assign set_one_hit = |(touched_map & set_one);
  assign set_two_hit = |(touched_map & set_two);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_start     <= 1'b0;
      touch_powerup   <= 1'b0;
      touch_scan_pads <= '0;
      touch_wake_irq  <= 1'b0;
    end else begin
      touch_start     <= t_seq_own ? seq_start : ctl[12][4];
      touch_powerup   <= t_seq_own ? seq_pwr : ctl[12][5];
      touch_scan_pads <= scan_set;
      touch_wake_irq  <= t_single ? set_one_hit : (set_one_hit & set_two_hit);
    end
  end

  // ------------------------------------------------------------
  // tone generator and dac outputs
  // ------------------------------------------------------------
  // quarter-wave table keeps the lut small at the cost of a little skew
  localparam logic [7:0] COS_Q [17] = '{8'd127, 8'd126, 8'd125, 8'd121, 8'd117, 8'd112,
                                        8'd106, 8'd98, 8'd90, 8'd81, 8'd71, 8'd60,
                                        8'd49, 8'd37, 8'd25, 8'd12, 8'd0};
  logic [15:0] phase;
  logic [3:0]  qi;
  logic [7:0]  wave;
  logic [7:0]  mag_a;
  logic [7:0]  mag_b;
  assign qi    = phase[13:10];
  assign mag_a = COS_Q[qi];
  assign mag_b = COS_Q[5'd16 - {1'b0, qi}];
  assign wave  = (phase[15:14] == 2'd0) ? mag_a :
                 (phase[15:14] == 2'd1) ? 8'(-mag_b) :
                 (phase[15:14] == 2'd2) ? 8'(-mag_a) : mag_b;

  function automatic logic [7:0] shape(input logic [7:0] w, input logic [1:0] sc,
                                       input logic [1:0] inv, input logic [7:0] dc);
    logic [7:0] s;
    logic [7:0] v;
    logic [8:0] sum;
    s = 8'($signed(w) >>> sc);
    case (inv)
      2'b01:   v = ~s;
      2'b10:   v = s ^ 8'h80;
      2'b11:   v = s ^ 8'h7f;
      default: v = s;
    endcase
    sum = {1'b0, v} + {1'b0, dc};
    return sum[8] ? 8'hff : sum[7:0];
  endfunction

  logic tone_on;
  logic mem_feed;
  assign tone_on  = ctl[16][16];
  assign mem_feed = ctl[16][17];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase    <= '0;
      dac_code <= '0;
      dac_clk  <= 1'b0;
    end else begin
      if (tone_on) begin
        phase <= phase + ctl[16][15:0];
      end
      for (int d = 0; d < 2; d++) begin
        if (mem_feed) begin
          dac_code[d] <= dac_dma_data[d];
        end else if (ctl[17][24 + d] && tone_on) begin
          dac_code[d] <= shape(wave, ctl[17][16 + 2*d +: 2], ctl[17][20 + 2*d +: 2],
                               ctl[17][8*d +: 8]);
        end else begin
          dac_code[d] <= ctl[18][8*d +: 8];
        end
      end
      dac_clk <= ctl[16][19] ? 1'b1 : ctl[16][20] ? 1'b0 :
                 ((mem_feed ? dac_dma_clk : dac_clk_in) ^ ctl[16][18]);
    end
  end

  // ------------------------------------------------------------
  // apb slave: no wait state, answer registered
  // ------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (idx)
      5'd5:              rd_val = {conv_result[0], 1'b0, conv_done[0], ctl[5][17:0]};
      5'd15:             rd_val = {conv_result[1], 1'b0, conv_done[1], ctl[15][17:0]};
      5'd12:             rd_val = {15'h0, 10'(touched_map), t_done, ctl[12][5:0]};
      5'd19, 5'd20, 5'd21, 5'd22, 5'd23: begin
        rd_val = {touch_count_in[2*(idx-19)+1], touch_count_in[2*(idx-19)]};
      end
      NO_REG:            rd_val = '0;
      default:           rd_val = ctl[idx];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata  <= pwrite ? 32'h0 : rd_val;
        pslverr <= idx == NO_REG;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESULT_INVERT: assert property (
    conv_in[0].done && invert_bit[0] |=> conv_result[0] == ~$past(conv_in[0].result))
    else $error("conversion result not inverted");
  AST_OWNER: assert property (
    ##1 conv_digital_owner[0] == $past(ctl[0][2])) else $error("owner bit not passed");
  AST_COPROC_SW: assert property (
    ctl[2][3] && !sw_go_write |=> !coproc_start) else $error("coprocessor started wrongly");
  AST_PADMAP: assert property (
    !pad_ovr[1] |=> conv_padmap[1] == $past(cop_padmap[1])) else $error("pad map source");
  AST_CONV_START: assert property (
    !trig_sel[0] |=> conv_start[0] == $past(cop_conv_start[0])) else $error("start source");
  AST_SEQ_ORDER: assert property (
    ts == TS_WAIT && cnt_end |=> ts == TS_MEAS ##1 seq_pwr) else $error("sequence order");
  AST_DONE_SET: assert property (
    ts == TS_DONE |=> t_done) else $error("done flag not set");
  AST_CLEAR: assert property (
    t_clr && ts != TS_DONE |=> touched_map == '0) else $error("touched map not cleared");
  AST_WAKE: assert property (
    !t_single && !set_two_hit |=> !touch_wake_irq) else $error("wake without both sets");
  AST_PHASE: assert property (
    tone_on |=> phase == 16'($past(phase) + $past(ctl[16][15:0]))) else $error("phase step");
  AST_APB_ANSWER: assert property (
    setup_ph |=> pready ##1 !pready) else $error("apb answer timing");

  COV_TOUCH_DONE: cover property (ts == TS_DONE);
  COV_WAKE: cover property (touch_wake_irq);
  COV_SATURATE: cover property (dac_code[0] == 8'hff && ctl[17][24]);
  COV_BAD_ADDR: cover property (pready && pslverr);
endmodule

// ### core/rsc_consts.svh
// constants for the low-power sensor control register bank
// assumes byte addressing on a 32-bit apb, one aligned word per register
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RSC_OFS_CONV1_READ_CONTROL     8'h00
`define RSC_OFS_COPROC_SLEEP_CYCLES    8'h18
`define RSC_OFS_START_FORCE_CONTROL    8'h2c
`define RSC_OFS_CONV1_PAD_ATTENUATION  8'h34
`define RSC_OFS_CONV2_PAD_ATTENUATION  8'h38
`define RSC_OFS_CONV1_MEASURE_START    8'h54
`define RSC_OFS_TOUCH_CONTROL_ONE      8'h58
`define RSC_OFS_TOUCH_THRESHOLD_BASE   8'h5c
`define RSC_OFS_TOUCH_COUNTER_BASE     8'h70
`define RSC_OFS_TOUCH_CONTROL_TWO      8'h84
`define RSC_OFS_TOUCH_PAD_SETS         8'h8c
`define RSC_OFS_CONV2_READ_CONTROL     8'h90
`define RSC_OFS_CONV2_MEASURE_START    8'h94
`define RSC_OFS_DAC_TONE_CONTROL       8'h98
`define RSC_OFS_DAC_OUTPUT_CONTROL     8'h9c
`define RSC_OFS_DAC_MANUAL_CODES       8'ha0
// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define RSC_RST_ATTENUATION            32'h0fffffff
`define RSC_MSK_READ_CONTROL           32'h00ffff0f
`define RSC_MSK_START_FORCE            32'h0000000f
`define RSC_MSK_MEASURE_START          32'h0003ff07
`define RSC_MSK_TOUCH_CONTROL_ONE      32'h03ffffff
`define RSC_MSK_TOUCH_CONTROL_TWO      32'h0000003e
`define RSC_MSK_TOUCH_PAD_SETS         32'h3fffffff
`define RSC_MSK_DAC_TONE               32'h001fffff
`define RSC_MSK_DAC_OUTPUT             32'h03ffffff
`define RSC_MSK_DAC_CODES              32'h0000ffff
`define RSC_MSK_ALL                    32'hffffffff
`endif

// ### core/rsc_pkg.sv
// types shared by the sensor control register bank
// assumes the constants header is included alongside
package rsc_pkg;
  // ------------------------------------------------------------
  // touch sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TS_IDLE,
    TS_WAIT,
    TS_MEAS,
    TS_DONE
  } rsc_touch_e;

  // ------------------------------------------------------------
  // one converter's report toward the bank
  // ------------------------------------------------------------
  typedef struct packed {
    logic        done;
    logic [11:0] result;
  } rsc_conv_in_s;
endpackage

// ### tb/rsc_far_model.sv
// far-side model: two converters, ten touch pad counters, 8 MHz strobe
// assumes starts and halts are pclk-synchronous levels from the bank
module rsc_far_model
  import rsc_pkg::*;
#(
  parameter logic [11:0] RES0 = 12'ha5c,
  parameter logic [11:0] RES1 = 12'h3c1
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [1:0]    conv_start,
  input  wire logic [1:0]    conv_halt,
  output rsc_conv_in_s [1:0] conv_in,
  output logic               tick_8m,
  output logic [9:0][15:0]   touch_count_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]      start_q;
  logic [1:0][2:0] busy;
  logic [1:0]      tcnt;
  // 8 MHz cannot divide 20 MHz evenly; one strobe every third cycle is close enough
  assign tick_8m = (tcnt == 2'd0);
  always_comb for (int k = 0; k < 10; k++) touch_count_in[k] = 16'(k * 256);
  // result toggles while converting so a stale capture shows up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= '0;
      busy    <= '0;
      tcnt    <= '0;
      conv_in <= '0;
    end else begin
      tcnt    <= (tcnt == 2'd2) ? 2'd0 : tcnt + 2'd1;
      start_q <= conv_start;
      for (int i = 0; i < 2; i++) begin
        if (conv_halt[i])
          busy[i] <= 3'd0;
        else if (conv_start[i] && !start_q[i])
          busy[i] <= 3'd4;
        else if (busy[i] != 3'd0)
          busy[i] <= busy[i] - 3'd1;
        conv_in[i].done <= (busy[i] == 3'd1) || (conv_in[i].done && busy[i] == 3'd0);
        if (busy[i] == 3'd1)
          conv_in[i].result <= i ? RES1 : RES0;
        else if (busy[i] != 3'd0)
          conv_in[i].result <= ~conv_in[i].result;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the sensor control register bank
// assumes apb answers within a few cycles and the far-side model above
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]         paddr = '0;
  logic [31:0]         pwdata = '0, prdata, rdat, coproc_sleep_cycles;
  logic                pready, pslverr, serr, coproc_start, tick_8m, cop_timer_tick = 0;
  rsc_conv_in_s [1:0]  conv_in;
  logic [1:0]          cop_conv_start = 2'b10, conv_digital_owner, conv_halt, conv_start;
  logic [1:0][9:0]     cop_padmap = {10'h0f0, 10'h2aa}, conv_padmap;
  logic [1:0][1:0]     conv_resolution;
  logic [1:0][31:0]    conv_attenuation;
  logic [9:0][15:0]    touch_count_in;
  logic                touch_start, touch_powerup, touch_wake_irq, dac_clk;
  logic [9:0]          touch_scan_pads;
  logic [1:0][7:0]     dac_dma_data = 16'h1234, dac_code;
  int                  n_errors = 0, checks_done = 0, n_go = 0;
  rsc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_in(conv_in), .cop_conv_start(cop_conv_start),
    .cop_padmap(cop_padmap), .cop_timer_tick(cop_timer_tick),
    .conv_digital_owner(conv_digital_owner), .conv_resolution(conv_resolution),
    .conv_halt(conv_halt), .conv_start(conv_start), .conv_padmap(conv_padmap),
    .conv_attenuation(conv_attenuation), .coproc_start(coproc_start),
    .coproc_sleep_cycles(coproc_sleep_cycles), .tick_8m(tick_8m),
    .touch_timer_tick(cop_timer_tick),
    .touch_count_in(touch_count_in), .touch_start(touch_start), .touch_powerup(touch_powerup),
    .touch_scan_pads(touch_scan_pads), .touch_wake_irq(touch_wake_irq), .dac_dma_clk(1'b0),
    .dac_dma_data(dac_dma_data), .dac_clk_in(1'b0), .dac_clk(dac_clk), .dac_code(dac_code));
  rsc_far_model i_far (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_halt(conv_halt), .conv_in(conv_in), .tick_8m(tick_8m),
    .touch_count_in(touch_count_in));
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (coproc_start === 1'b1) n_go++;
  // ----
  // shared tasks
  // ----
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // called just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) give_up();
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(12'h034, 32'h0fffffff);
    rd(12'h038, 32'h0fffffff);
    apb(1'b1, 12'h034, 32'h0000001b);
    apb(1'b1, 12'h018, 32'hdeadbeef);
    rd(12'h018, 32'hdeadbeef);
    chk(conv_attenuation[0], 32'h0000001b);
    chk(coproc_sleep_cycles, 32'hdeadbeef);
    apb(1'b1, 12'h070, 32'hffffffff);
    rd(12'h070, 32'h01000000);
    rd(12'h100, 32'h0);
    chk(32'(serr), 32'h1);
    $display("test regs done");
  endtask
  task automatic t_conv();
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, 32'(k) | 32'h8);
      cyc(3);
      chk(conv_resolution[0], 32'(k));
    end
    apb(1'b1, 12'h090, 32'h00000004);
    apb(1'b1, 12'h054, 32'h00015504);
    cyc(3);
    chk(conv_digital_owner, 32'h2);
    chk(conv_padmap, 32'h3c155);
    chk(conv_start, 32'h2);
    apb(1'b1, 12'h054, 32'h00000003);
    cyc(12);
    rd(12'h054, 32'h5a340003);
    rd(12'h094, 32'h3c140000);
    chk(conv_padmap[0], 32'h2aa);
    $display("test conv done");
  endtask
  task automatic t_coproc();
    int k;
    k = n_go;
    apb(1'b1, 12'h02c, 32'h00000007);
    cyc(4);
    chk(32'(n_go - k), 32'h0);
    chk(conv_halt, 32'h3);
    apb(1'b1, 12'h02c, 32'h00000008);
    apb(1'b1, 12'h02c, 32'h0000000c);
    cyc(4);
    chk(32'(n_go - k), 32'h1);
    chk(conv_halt, 32'h0);
    apb(1'b1, 12'h02c, 32'h00000000);
    cop_timer_tick <= 1'b1;
    @(posedge pclk);
    cop_timer_tick <= 1'b0;
    cyc(4);
    chk(32'(n_go - k), 32'h2);
    cyc(8);
    rd(12'h084, 32'h00000040);
    $display("test coproc done");
  endtask
  task automatic t_touch();
    int n;
    for (int k = 0; k < 5; k++) apb(1'b1, 12'h05c + 12'(4 * k), 32'h04500450);
    apb(1'b1, 12'h08c, 32'h3ff00600);
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, 12'h058, 32'h00000302 | (32'(s) << 24) | (32'(s) << 25));
      apb(1'b1, 12'h084, 32'h00000001);
      apb(1'b1, 12'h084, 32'h0000000e);
      apb(1'b1, 12'h084, 32'h0000000a);
      cyc(3);
      n = 0;
      do begin
        apb(1'b0, 12'h084, 32'h0);
        n++;
      end while (rdat[6] !== 1'b1 && n < 100);
      if (n >= 100) give_up();
      rd(12'h084, s ? 32'h0001f04a : 32'h00000fca);
      cyc(3);
      chk(touch_wake_irq, 32'(s));
    end
    chk(touch_scan_pads, 32'h3ff);
    apb(1'b1, 12'h084, 32'h00000010);
    cyc(3);
    chk({touch_start, touch_powerup}, 32'h2);
    apb(1'b1, 12'h084, 32'h00000001);
    rd(12'h084, 32'h00000040);
    $display("test touch done");
  endtask
  task automatic t_dac();
    apb(1'b1, 12'h0a0, 32'h00003c5a);
    apb(1'b1, 12'h09c, 32'h010000ff);
    cyc(3);
    chk(dac_code, 32'h3c5a);
    apb(1'b1, 12'h098, 32'h00010000);
    cyc(3);
    chk(dac_code, 32'h3cff);
    apb(1'b1, 12'h09c, 32'h01110000);
    cyc(3);
    chk(dac_code, 32'h3cc0);
    apb(1'b1, 12'h098, 32'h00020000);
    cyc(3);
    chk(dac_code, 32'h1234);
    apb(1'b1, 12'h098, 32'h00040000);
    cyc(3);
    chk(dac_clk, 32'h1);
    apb(1'b1, 12'h098, 32'h00140000);
    cyc(3);
    chk(dac_clk, 32'h0);
    $display("test dac done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_conv();
    t_coproc();
    t_touch();
    t_dac();
    end_sim();
  end
endmodule
